// *** ecp_monitor.sv ***
`timescale 1ns/10ps
module ecp_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // host port
  input wire logic [10:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic DACK,
  input wire logic [7:0] RDATA,
  input wire logic DRQ,
  // link
  input wire logic [7:0] PD_OUT,
  input wire logic PD_OE,
  input wire logic NSTROBE,
  input wire logic NINIT,
  input wire logic BUSY
);
  logic [5:0] ctrl_q;
  logic [2:0] mode_q;
  logic dma_q;
  wire wr_ctrl = WR && !DACK && ADDR == ecp_pkg::OFS_CTRL;
  wire wr_ext = WR && !DACK && ADDR == ecp_pkg::OFS_EXT;
  wire fifo_m = mode_q[2:1] == 2'h1;
  wire e_fwd = mode_q == 3'h3 && !ctrl_q[5];
  wire e_rev = mode_q == 3'h3 && ctrl_q[5];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= 6'h00;
      mode_q <= 3'h0;
      dma_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= WDATA[5:0];
      if (wr_ext) mode_q <= WDATA[7:5];
      if (wr_ext) dma_q <= WDATA[3];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_setup; $fell(NSTROBE) |-> PD_OE && $stable(PD_OUT); endproperty
  a_setup: assert property (p_setup) else $error("strobe without stable data");
  property p_hold; fifo_m && !NSTROBE && !BUSY |=> !NSTROBE; endproperty
  a_hold: assert property (p_hold) else $error("strobe released before busy");
  property p_rel; fifo_m && $rose(BUSY) && !NSTROBE |-> ##[1:8] NSTROBE; endproperty
  a_rel: assert property (p_rel) else $error("strobe not released");
  property p_fwd; e_fwd && $past(e_fwd, 2) |-> NINIT && PD_OE; endproperty
  a_fwd: assert property (p_fwd) else $error("forward direction pins wrong");
  property p_rev; e_rev && $past(e_rev, 2) |-> !NINIT && !PD_OE; endproperty
  a_rev: assert property (p_rev) else $error("reverse direction pins wrong");
  property p_ctrl; RD && !DACK && ADDR == ecp_pkg::OFS_CTRL |=> RDATA == {2'h0, $past(ctrl_q)}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_ext; RD && !DACK && ADDR == ecp_pkg::OFS_EXT |=> RDATA[7:5] == $past(mode_q) && RDATA[3] == $past(dma_q);
  endproperty
  a_ext: assert property (p_ext) else $error("mode readback wrong");
  property p_dma; !dma_q |-> !DRQ; endproperty
  a_dma: assert property (p_dma) else $error("dma request while disabled");
  c_fwd: cover property ($fell(NSTROBE) && e_fwd);
  c_rev: cover property (e_rev && !NINIT);
  c_drq: cover property (DRQ);
endmodule
bind ecp_parallel_port ecp_monitor i_ecp_monitor (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .DACK, .RDATA, .DRQ,
  .PD_OUT, .PD_OE, .NSTROBE, .NINIT, .BUSY);

// *** ecp_parallel_port.sv ***
`timescale 1ns/10ps
// What this block does
// [RQ1] Every word moved over the link or the host port is one 8-bit byte.
// [RQ2] All four queues share one 16-byte store.
// [RQ3] No negotiation is done; forward and reverse bursts run on their own, with DMA requests.
// [RQ4] In the compatibility queue mode the strobe and busy handshake is generated by hardware.
// [RQ5] A received run-length byte is withheld and the next data byte is stored that many times plus one.
// [RQ6] Hardware compression is left out, and the capability word reports it as absent.
// [RQ7] Forward bytes are set up on the data lines before nStrobe asserts, interlocked with Busy.
// [RQ8] The peripheral marks valid reverse data with nAck, interlocked with the host acknowledge line.
// [RQ9] The peripheral drops Busy when it can accept a forward byte and raises it to interlock nStrobe.
// [RQ10] In reverse the peripheral uses Busy to mark a command byte or a data byte.
// [RQ11] Status and control registers answer in every mode.
// [RQ12] Bytes written to the address queue are sent as address or run-length bytes, not data.
// [RQ13] The three-bit mode field codes 000 to 111 select standard to configuration operation in order.
// [RQ14] nInit is driven low for reverse and high for forward transfers.
// [RQ15] In forward transfers the host acknowledge line tells command byte from data byte.
// [RQ16] The full and empty flags track the shared store at every moment.
module ecp_parallel_port (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // host register port
  input wire logic [10:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // dma handshake
  output logic DRQ,
  input wire logic DACK,
  // link data lines
  input wire logic [7:0] PD_IN,
  output logic [7:0] PD_OUT,
  output logic PD_OE,
  // link control outputs
  output logic NSTROBE,
  output logic NAUTOFD,
  output logic NINIT,
  output logic NSELECTIN,
  // link status inputs
  input wire logic BUSY,
  input wire logic NACK,
  input wire logic PERROR,
  input wire logic SELECT,
  input wire logic NFAULT
);
  typedef enum {F_IDLE, F_SETUP, F_STROBE} ecp_fwd_type;
  typedef enum {R_IDLE, R_ACK} ecp_rev_type;
  // input pins: three flops, accept when the last two agree
  logic [ecp_pkg::PIN_W-1:0] raw, s1_q, s2_q, s3_q, filt_q;
  ecp_pkg::ecp_pins_type pin;
  assign raw = {NACK, BUSY, PERROR, SELECT, NFAULT, PD_IN};
  assign pin = ecp_pkg::ecp_pins_type'(filt_q);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_q <= '1; // same level as the filter, so no false low after reset
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < ecp_pkg::PIN_W; gi++) begin : g_filt
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          filt_q[gi] <= 1'b1;
        end else if (s2_q[gi] == s3_q[gi]) begin
          filt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate
  // registers
  logic [7:0] data_q, ctrl_q;
  logic [2:0] mode_q;
  logic nerrie_q, dma_q, svc_q;
  ecp_pkg::ecp_mode_type mode;
  assign mode = ecp_pkg::ecp_mode_type'(mode_q); // RQ13
  wire dir = ctrl_q[ecp_pkg::CTRL_DIR];
  wire sel_data = ADDR == ecp_pkg::OFS_DATA;
  wire sel_queue = (ADDR == ecp_pkg::OFS_QUEUE) | DACK;
  wire sel_ext = ADDR == ecp_pkg::OFS_EXT;
  wire wr_ctrl = WR & ~DACK & ADDR == ecp_pkg::OFS_CTRL; // RQ11
  wire wr_ext = WR & sel_ext & ~DACK;
  wire fwd_run = (mode == ecp_pkg::MODE_ECP & ~dir) | mode == ecp_pkg::MODE_COMPAT;
  wire rev_run = mode == ecp_pkg::MODE_ECP & dir;
  wire legacy = mode == ecp_pkg::MODE_SPP | mode == ecp_pkg::MODE_PS2;
  wire flush = wr_ext & WDATA[7:6] == 2'b00;
  // shared 16-byte store
  ecp_pkg::ecp_entry_type mem_q [ecp_pkg::DEPTH];
  logic [ecp_pkg::PTR_W-1:0] wp_q, rp_q;
  wire [ecp_pkg::PTR_W-1:0] used = wp_q - rp_q;
  wire q_full = used == 5'h10; // RQ16
  wire q_empty = used == 5'h00; // RQ16
  logic rev_push;
  logic [7:0] rev_byte_q;
  wire host_fwd = mode == ecp_pkg::MODE_COMPAT | (mode == ecp_pkg::MODE_ECP & ~dir) | mode == ecp_pkg::MODE_TEST;
  wire host_cmd = WR & sel_data & ~DACK & mode == ecp_pkg::MODE_ECP & ~dir; // RQ12
  wire host_dat = WR & sel_queue & host_fwd;
  wire push = (host_cmd | host_dat | rev_push) & ~q_full; // RQ2
  ecp_pkg::ecp_entry_type push_e;
  assign push_e = {~rev_push & host_cmd, rev_push ? rev_byte_q : WDATA};
  wire host_pop = RD & sel_queue & (rev_run | mode == ecp_pkg::MODE_TEST) & ~q_empty;
  logic sk_load;
  wire pop = host_pop | sk_load;
  ecp_pkg::ecp_entry_type head;
  assign head = mem_q[rp_q[3:0]];
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 5'h01;
      end
      if (pop) begin
        rp_q <= rp_q + 5'h01;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (push) begin
      mem_q[wp_q[3:0]] <= push_e;
    end
  end
  // two-entry buffer between the store and the forward engine
  ecp_pkg::ecp_entry_type sk_q [2];
  logic [1:0] sk_cnt_q;
  logic sk_take;
  wire sk_ready = sk_cnt_q != 2'd2;
  wire sk_valid = sk_cnt_q != 2'd0;
  assign sk_load = fwd_run & ~q_empty & sk_ready;
  wire [1:0] sk_widx = sk_cnt_q - {1'b0, sk_take};
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sk_cnt_q <= 2'd0;
    end else if (flush | ~fwd_run) begin
      sk_cnt_q <= 2'd0;
    end else begin
      sk_cnt_q <= sk_cnt_q + {1'b0, sk_load} - {1'b0, sk_take};
    end
  end
  always_ff @(posedge CLK) begin
    if (sk_take) begin
      sk_q[0] <= sk_q[1];
    end
    if (sk_load) begin
      sk_q[sk_widx[0]] <= head;
    end
  end
  // forward engine
  ecp_fwd_type f_q;
  logic [5:0] f_cnt_q;
  logic [7:0] f_pd_q;
  logic f_alf_q, f_nstb_q;
  assign sk_take = f_q == F_IDLE & fwd_run & sk_valid & ~pin.busy; // RQ9
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      f_q <= F_IDLE;
      f_cnt_q <= 6'h00;
      f_pd_q <= 8'h00;
      f_alf_q <= 1'b1;
      f_nstb_q <= 1'b1;
    end else if (~fwd_run) begin
      f_q <= F_IDLE;
      f_nstb_q <= 1'b1;
    end else begin
      case (f_q)
        F_IDLE: begin
          if (sk_take) begin
            f_pd_q <= sk_q[0].byte_v; // RQ1
            f_alf_q <= ~sk_q[0].cmd; // RQ15
            f_cnt_q <= ecp_pkg::SETUP_CNT;
            f_q <= F_SETUP;
          end
        end
        F_SETUP: begin
          if (f_cnt_q == 6'h00) begin
            f_nstb_q <= 1'b0; // RQ7
            f_q <= F_STROBE;
          end else begin
            f_cnt_q <= f_cnt_q - 6'h01;
          end
        end
        F_STROBE: begin
          if (pin.busy) begin
            f_nstb_q <= 1'b1; // RQ4
            f_q <= F_IDLE;
          end
        end
        default: begin
          f_q <= F_IDLE;
        end
      endcase
    end
  end
  // reverse engine with run-length expansion
  ecp_rev_type r_q;
  logic r_hack_q, rle_pend_q;
  logic [7:0] rle_q, rep_q;
  assign rev_push = rep_q != 8'h00;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r_q <= R_IDLE;
      r_hack_q <= 1'b0;
      rle_pend_q <= 1'b0;
      rle_q <= 8'h00;
      rep_q <= 8'h00;
      rev_byte_q <= 8'h00;
    end else if (~rev_run) begin
      r_q <= R_IDLE;
      r_hack_q <= 1'b0;
      rle_pend_q <= 1'b0;
      rep_q <= 8'h00;
    end else begin
      if (rev_push & ~q_full) begin
        rep_q <= rep_q - 8'h01;
      end
      case (r_q)
        R_IDLE: begin
          if (~pin.nack & ~rev_push & ~q_full) begin // RQ8
            r_hack_q <= 1'b1;
            r_q <= R_ACK;
            if (~pin.busy & ~pin.pd[7]) begin // RQ10
              rle_q <= {1'b0, pin.pd[6:0]}; // RQ5
              rle_pend_q <= 1'b1;
            end else if (pin.busy) begin
              rev_byte_q <= pin.pd;
              rep_q <= rle_pend_q ? rle_q + 8'h01 : 8'h01; // RQ5
              rle_pend_q <= 1'b0;
            end
          end
        end
        R_ACK: begin
          if (pin.nack) begin
            r_hack_q <= 1'b0;
            r_q <= R_IDLE;
          end
        end
        default: begin
          r_q <= R_IDLE;
        end
      endcase
    end
  end
  // register writes
  wire svc_set = dma_q & ((fwd_run & q_empty) | (rev_run & q_full));
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      data_q <= ecp_pkg::DATA_RESET;
      ctrl_q <= ecp_pkg::CTRL_RESET;
      mode_q <= 3'h0;
      nerrie_q <= 1'b0;
      dma_q <= 1'b0;
      svc_q <= 1'b0;
    end else begin
      if (WR & sel_data & ~DACK & legacy) begin
        data_q <= WDATA;
      end
      if (wr_ctrl) begin
        ctrl_q <= {2'b00, WDATA[5:0]};
      end
      if (wr_ext) begin
        mode_q <= WDATA[7:5]; // RQ13
        nerrie_q <= WDATA[ecp_pkg::EXT_NERRIE];
        dma_q <= WDATA[ecp_pkg::EXT_DMA];
      end
      svc_q <= svc_set | (wr_ext ? WDATA[ecp_pkg::EXT_SVC] : svc_q);
    end
  end
  // register reads
  wire [7:0] status_v = {~pin.busy, pin.nack, pin.perror, pin.select, pin.nfault, 3'b000}; // RQ11
  wire [7:0] ext_v = {mode_q, nerrie_q, dma_q, svc_q, q_full, q_empty}; // RQ16
  wire [7:0] capb_v = 8'h00; // RQ6
  logic [7:0] rd_v;
  always_comb begin
    rd_v = 8'h00;
    if (sel_queue) begin
      if (mode == ecp_pkg::MODE_CONFIG & ~DACK) begin
        rd_v = ecp_pkg::CAPA_VALUE;
      end else begin
        rd_v = head.byte_v;
      end
    end else if (sel_data) begin
      rd_v = (mode == ecp_pkg::MODE_PS2 & dir) ? pin.pd : data_q;
    end else if (ADDR == ecp_pkg::OFS_STATUS) begin
      rd_v = status_v;
    end else if (ADDR == ecp_pkg::OFS_CTRL) begin
      rd_v = ctrl_q;
    end else if (ADDR == ecp_pkg::OFS_CAPB & mode == ecp_pkg::MODE_CONFIG) begin
      rd_v = capb_v;
    end else if (sel_ext) begin
      rd_v = ext_v;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_v;
    end
  end
  assign DRQ = dma_q & ((fwd_run & ~q_full) | (rev_run & ~q_empty)); // RQ3
  // link outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PD_OUT <= 8'h00;
      PD_OE <= 1'b1;
      NSTROBE <= 1'b1;
      NAUTOFD <= 1'b1;
      NINIT <= 1'b0;
      NSELECTIN <= 1'b1;
    end else if (legacy) begin
      PD_OUT <= data_q;
      PD_OE <= ~(mode == ecp_pkg::MODE_PS2 & dir);
      NSTROBE <= ~ctrl_q[ecp_pkg::CTRL_STROBE];
      NAUTOFD <= ~ctrl_q[ecp_pkg::CTRL_ALF];
      NINIT <= ctrl_q[ecp_pkg::CTRL_INIT];
      NSELECTIN <= ~ctrl_q[ecp_pkg::CTRL_SELIN];
    end else begin
      PD_OUT <= f_pd_q;
      PD_OE <= ~rev_run;
      NSTROBE <= f_nstb_q;
      NAUTOFD <= mode == ecp_pkg::MODE_ECP ? (dir ? r_hack_q : f_alf_q) : ~ctrl_q[ecp_pkg::CTRL_ALF]; // RQ15
      NINIT <= mode == ecp_pkg::MODE_ECP ? ~dir : ctrl_q[ecp_pkg::CTRL_INIT]; // RQ14
      NSELECTIN <= ~ctrl_q[ecp_pkg::CTRL_SELIN];
    end
  end
endmodule

// *** ecp_periph.sv ***
`timescale 1ns/10ps
module ecp_periph (
  // from host
  input wire logic clk,
  input wire logic [7:0] pd_out,
  input wire logic nstrobe,
  input wire logic nautofd,
  // to host
  output logic [7:0] pd_in,
  output logic busy,
  output logic nack
);
  logic [8:0] got[$];
  int lag = 0;
  initial begin
    pd_in = 8'h00;
    busy = 1'b0;
    nack = 1'b1;
    forever begin
      @(posedge clk);
      if (!nstrobe) begin
        got.push_back({nautofd, pd_out});
        busy <= 1'b1;
        while (!nstrobe) @(posedge clk);
        repeat (lag) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
  task automatic send(input logic [7:0] b, input logic cmd);
    pd_in <= b;
    busy <= !cmd;
    repeat (2) @(posedge clk);
    nack <= 1'b0;
    for (int i = 0; i < 40 && !nautofd; i++) @(posedge clk);
    nack <= 1'b1;
    for (int i = 0; i < 40 && nautofd; i++) @(posedge clk);
    pd_in <= ~b;
  endtask
endmodule

// *** ecp_pkg.sv ***
package ecp_pkg;
  localparam int DW = 8;
  localparam int DEPTH = 16;
  localparam int PTR_W = 5;
  localparam int PIN_W = 13;
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CTRL = 11'h002;
  localparam logic [10:0] OFS_QUEUE = 11'h400;
  localparam logic [10:0] OFS_CAPB = 11'h401;
  localparam logic [10:0] OFS_EXT = 11'h402;
  localparam logic [7:0] CAPA_VALUE = 8'h10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_ALF = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SELIN = 3;
  localparam int CTRL_ACKIE = 4;
  localparam int CTRL_DIR = 5;
  localparam int EXT_EMPTY = 0;
  localparam int EXT_FULL = 1;
  localparam int EXT_SVC = 2;
  localparam int EXT_DMA = 3;
  localparam int EXT_NERRIE = 4;
  localparam int EXT_MODE_LSB = 5;
  localparam int CLK_MHZ = 40;
  localparam int SETUP_NS = 500;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0] SETUP_CNT = 6'(SETUP_CYC);
  typedef enum logic [2:0] {
    MODE_SPP = 3'b000,
    MODE_PS2 = 3'b001,
    MODE_COMPAT = 3'b010,
    MODE_ECP = 3'b011,
    MODE_EPP = 3'b100,
    MODE_RSVD = 3'b101,
    MODE_TEST = 3'b110,
    MODE_CONFIG = 3'b111
  } ecp_mode_type;
  typedef struct packed {
    logic cmd;
    logic [7:0] byte_v;
  } ecp_entry_type;
  typedef struct packed {
    logic nack;
    logic busy;
    logic perror;
    logic select;
    logic nfault;
    logic [7:0] pd;
  } ecp_pins_type;
endpackage

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
  localparam logic [10:0] AQ = ecp_pkg::OFS_QUEUE;
  localparam logic [10:0] AE = ecp_pkg::OFS_EXT;
  localparam logic [10:0] AC = ecp_pkg::OFS_CTRL;
  logic clk, rst, wr_s, rd_s, dack, drq, pd_oe, nstrobe, nautofd, ninit, nselectin, busy, nack;
  logic [10:0] addr;
  logic [7:0] wdata, rdata, pd_in, pd_out;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  ecp_parallel_port i_ecp_parallel_port (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .DRQ(drq), .DACK(dack), .PD_IN(pd_in), .PD_OUT(pd_out), .PD_OE(pd_oe), .NSTROBE(nstrobe),
    .NAUTOFD(nautofd), .NINIT(ninit), .NSELECTIN(nselectin), .BUSY(busy), .NACK(nack), .PERROR(1'b0), .SELECT(1'b1),
    .NFAULT(1'b0));
  ecp_periph i_ecp_periph (.clk(clk), .pd_out(pd_out), .nstrobe(nstrobe), .nautofd(nautofd), .pd_in(pd_in),
    .busy(busy), .nack(nack));
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [10:0] a, input logic [7:0] d, input logic k);
    addr <= a;
    wdata <= d;
    dack <= k;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    dack <= 1'b0;
    @(posedge clk);
  endtask
  task automatic get(input logic [10:0] a, input logic [7:0] e, input logic k, input logic [7:0] m = 8'hff);
    addr <= a;
    dack <= k;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    dack <= 1'b0;
    @(posedge clk);
    chk(rdata & m, e);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && i_ecp_periph.got.size() < n; i++) @(posedge clk);
  endtask
  task automatic t_regs();
    get(AC, 8'h00, 0);
    get(AE, 8'h01, 0);
    put(AC, 8'h1c, 0);
    for (int m = 0; m < 8; m++) begin
      put(AE, {m[2:0], 5'h00}, 0);
      get(AE, {m[2:0], 5'h01}, 0);
      get(AC, 8'h1c, 0);
      if (m == 0) chk({8'h0, nselectin}, 9'h000);
      get(ecp_pkg::OFS_STATUS, 8'hd0, 0);
    end
    get(AQ, 8'h10, 0);
    get(ecp_pkg::OFS_CAPB, 8'h00, 0);
    get(11'h003, 8'h00, 0);
    $display("test regs done");
  endtask
  task automatic t_fifo();
    put(AE, 8'hc0, 0);
    for (int i = 0; i < 17; i++) put(AQ, 8'(i + 48), i[0]);
    get(AE, 8'hc2, 0);
    for (int i = 0; i < 16; i++) get(AQ, 8'(i + 48), i[0]);
    get(AE, 8'hc1, 0);
    $display("test fifo done");
  endtask
  task automatic t_fwd();
    i_ecp_periph.lag = 300;
    put(AE, 8'h68, 0);
    chk({8'h0, drq}, 9'h001);
    put(ecp_pkg::OFS_DATA, 8'h85, 0);
    for (int i = 0; i < 18; i++) put(AQ, 8'(i + 96), 1);
    get(AE, 8'h02, 0, 8'h03);
    chk({8'h0, drq}, 9'h000);
    i_ecp_periph.lag = 2;
    wait_got(19);
    chk(i_ecp_periph.got[0], 9'h085);
    for (int i = 1; i < 19; i++) chk(i_ecp_periph.got[i], 9'(i + 351));
    $display("test forward done");
  endtask
  task automatic t_compat();
    i_ecp_periph.got.delete();
    put(AE, 8'h40, 0);
    put(AQ, 8'h3c, 0);
    put(AQ, 8'hc3, 0);
    wait_got(2);
    chk({1'b0, i_ecp_periph.got[0][7:0]}, 9'h03c);
    chk({1'b0, i_ecp_periph.got[1][7:0]}, 9'h0c3);
    $display("test compat done");
  endtask
  task automatic t_rev();
    put(AC, 8'h3c, 0);
    put(AE, 8'h60, 0);
    repeat (3) @(posedge clk);
    chk({7'h0, ninit, pd_oe}, 9'h000);
    i_ecp_periph.send(8'h03, 1);
    i_ecp_periph.send(8'haa, 0);
    i_ecp_periph.send(8'h81, 1);
    i_ecp_periph.send(8'h5b, 0);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 4; i++) get(AQ, 8'haa, 0);
    get(AQ, 8'h5b, 0);
    get(AE, 8'h01, 0, 8'h03);
    $display("test reverse done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    addr = 11'h000;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    dack = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_regs();
    t_fifo();
    t_fwd();
    t_compat();
    t_rev();
    end_of_test();
  end
endmodule
